//--- logic/mcsi_pkg.sv
// shared constants and types for the cpu-space interface of the mmu
// assumes a single 20 mhz clock shared by both ends
package mcsi_pkg;
    localparam int LA_W = 32;                          // full logical address
    localparam int PA_W = 32;                          // physical address
    localparam int D_W  = 16;                          // register data width
    localparam int FC_W = 3;                           // function code width
    localparam logic [2:0] FC_CPU   = 3'h7;            // cpu space code
    localparam int CPU_TYPE_LO      = 16;              // space type field lsb
    localparam logic [3:0] TYPE_BKPT = 4'h0;           // breakpoint ack
    localparam logic [3:0] TYPE_ALC  = 4'h1;           // access level ctl
    localparam logic [3:0] TYPE_COP  = 4'h2;           // coprocessor
    localparam int CPID_LO          = 13;              // coproc id lsb
    localparam logic [2:0] MY_CPID  = 3'h0;            // our coproc id
    localparam int NUM_CIR          = 11;              // interface regs
    localparam int NUM_ALC          = 8;               // access level regs
    localparam int NUM_BKPT         = 8;               // breakpoint pairs
    localparam int SEL_W            = 5;               // word select width
    localparam logic [4:0] CIR_RESP  = 5'h00;          // response
    localparam logic [4:0] CIR_CMD   = 5'h02;          // command (instr)
    localparam logic [4:0] CIR_OPER  = 5'h08;          // operand
    localparam logic [15:0] RESP_IDLE  = 16'h0802;     // done, no service
    localparam logic [15:0] RESP_FETCH = 16'h9504;     // fetch ea operand
    localparam int TC_ENTRIES       = 8;               // translation cache
    localparam int PAGE_LO          = 12;              // page offset bits
    localparam int WALK_CYC         = 4;               // descriptor read len
    typedef logic [LA_W-PAGE_LO-1:0] mcsi_page_t;      // page number
endpackage

//--- logic/mcsi_if.sv
// logical and physical bus signals between processor end and mmu end
// the testbench instances this and joins both ends through it
`timescale 1ns/1ps
interface mcsi_if;
    import mcsi_pkg::*;
    logic [LA_W-1:0] la;        // logical address
    logic [FC_W-1:0] fc;        // function code
    logic            as_n;      // logical address strobe, low
    logic            rw;        // high = read
    logic [D_W-1:0]  dout_cpu;  // processor write data
    logic [D_W-1:0]  dout_mmu;  // mmu read data
    logic            ack_n;     // mmu terminates cycle, low
    logic            retry_n;   // mmu asks retry, low
    logic            br_n;      // mmu requests logical bus, low
    logic            bg_n;      // processor grants bus, low
    logic [PA_W-1:0] pa;        // physical address
    logic            pas_n;     // physical_addr_strobe, low
    logic            pbusy;     // walk cycle active on physical bus
    logic            pack_n;    // memory acknowledge, low
    logic [D_W-1:0]  pdata;     // memory read data
    logic            fault;     // write-protect violation pulse
    modport mmu (input la, fc, as_n, rw, dout_cpu, bg_n, pack_n, pdata,
                 output dout_mmu, ack_n, retry_n, br_n, pa, pas_n,
                 pbusy, fault);
    modport cpu (output la, fc, as_n, rw, dout_cpu, bg_n,
                 input dout_mmu, ack_n, retry_n, br_n, fault);
endinterface

//--- logic/mcsi_mmu.sv
// mmu end: cpu space decode, register groups, translation, table walk
// assumes the processor holds address and strobe stable through a cycle
`timescale 1ns/1ps
module mcsi_mmu
    import mcsi_pkg::*;
(
    input  wire logic      clk,
    input  wire logic      nrst,
    mcsi_if.mmu            bus,
    input  wire logic      wr_protect,  // global write-protect switch
    output logic [D_W-1:0] last_cmd,    // last instruction received
    output logic           walk_busy    // table walk in progress
);
    import mcsi_pkg::*;

    typedef enum logic [1:0] {
        S_IDLE = 2'b00,   // watching the logical bus
        S_REQ  = 2'b01,   // bus requested after a miss
        S_WALK = 2'b10,   // descriptor read on physical bus
        S_DONE = 2'b11    // release bus
    } mcsi_st_e;

    typedef struct packed {
        mcsi_st_e                         st;
        logic [NUM_CIR-1:0][D_W-1:0]      coproc_interface_reg;    // interface regs
        logic [NUM_ALC-1:0][D_W-1:0]      alc;    // access level regs
        logic [NUM_BKPT-1:0][D_W-1:0]     bkd;    // breakpoint data
        logic [NUM_BKPT-1:0][D_W-1:0]     bkc;    // breakpoint control
        logic [TC_ENTRIES-1:0]            vld;    // cache valid bits
        logic [TC_ENTRIES-1:0][LA_W-PAGE_LO-1:0] tag;
        logic [TC_ENTRIES-1:0][PA_W-PAGE_LO-1:0] frm;
        logic [2:0]                       vict;   // round-robin victim
        logic [2:0]                       wcnt;   // walk cycle count
        logic [D_W-1:0]                   dout;
        logic                             ack;
        logic                             retry;
        logic                             br;
        logic [PA_W-1:0]                  pa;
        logic                             physical_addr_strobe;
        logic                             pbusy;
        logic                             fault;
        logic                             seen;   // cycle already served
    } mcsi_state_s;

    mcsi_state_s s_r, s_nxt;

    // cpu space decode, purely from logical address and function code
    logic cpu_sp, is_cop, is_alc, is_bkp, sel_ok, hit, strobe;
    logic [SEL_W-1:0] wsel;
    logic [2:0]       hit_idx;
    mcsi_page_t       page;
    assign strobe = ~bus.as_n;
    assign cpu_sp = (bus.fc == FC_CPU);
    assign wsel   = bus.la[SEL_W-1:0];
    assign is_cop = cpu_sp && bus.la[CPU_TYPE_LO +: 4] == TYPE_COP
                 && bus.la[CPID_LO +: 3] == MY_CPID
                 && wsel < SEL_W'(NUM_CIR);
    assign is_alc = cpu_sp && bus.la[CPU_TYPE_LO +: 4] == TYPE_ALC
                 && wsel < SEL_W'(NUM_ALC);
    assign is_bkp = cpu_sp && bus.la[CPU_TYPE_LO +: 4] == TYPE_BKPT;
    assign sel_ok = is_cop | is_alc | is_bkp;
    assign page   = bus.la[LA_W-1:PAGE_LO];

    // fully associative lookup, combinational so a hit costs no cycle
    always_comb begin
        hit     = 1'b0;
        hit_idx = 3'h0;
        for (int i = 0; i < TC_ENTRIES; i++) begin
            if (s_r.vld[i] && s_r.tag[i] == page) begin
                hit     = 1'b1;
                hit_idx = 3'(i);
            end
        end
    end

    // next-state logic for the whole end
    always_comb begin
        s_nxt       = s_r;
        s_nxt.ack   = 1'b0;
        s_nxt.retry = 1'b0;
        s_nxt.fault = 1'b0;
        if (!strobe) begin
            s_nxt.seen = 1'b0;
            // a walk holds its own strobe until memory answers or wcnt reaches WALK_CYC
            if (!s_r.pbusy) begin
                s_nxt.physical_addr_strobe = 1'b0;
            end
        end
        unique case (s_r.st)
            S_IDLE: begin
                if (strobe && !s_r.seen && cpu_sp) begin
                    s_nxt.seen = 1'b1;
                    if (sel_ok) begin
                        s_nxt.ack = 1'b1;
                        if (is_cop) begin
                            if (!bus.rw) begin
                                s_nxt.coproc_interface_reg[wsel] = bus.dout_cpu;
                                if (wsel == CIR_CMD) begin
                                    // ask for an operand once
                                    s_nxt.coproc_interface_reg[CIR_RESP] = RESP_FETCH;
                                end
                                if (wsel == CIR_OPER) begin
                                    s_nxt.coproc_interface_reg[CIR_RESP] = RESP_IDLE;
                                end
                            end else begin
                                s_nxt.dout = s_r.coproc_interface_reg[wsel];
                            end
                        end else if (is_alc) begin
                            if (!bus.rw) begin
                                s_nxt.alc[wsel[2:0]] = bus.dout_cpu;
                            end else begin
                                s_nxt.dout = s_r.alc[wsel[2:0]];
                            end
                        end else if (!bus.rw) begin
                            // setup write loads the replacement word
                            s_nxt.bkd[bus.la[4:2]] = bus.dout_cpu;
                        end else begin
                            // breakpoint vector picks the register pair
                            s_nxt.dout = s_r.bkd[bus.la[4:2]];
                            s_nxt.bkc[bus.la[4:2]] =
                                s_r.bkc[bus.la[4:2]] + 16'h0001;
                        end
                    end
                    // other cpu space cycles are left to other logic
                end else if (strobe && !s_r.seen && !cpu_sp) begin
                    if (hit) begin
                        if (!bus.rw && wr_protect) begin
                            s_nxt.fault = 1'b1;
                            s_nxt.seen  = 1'b1;
                        end else begin
                            s_nxt.pa  = {s_r.frm[hit_idx],
                                         bus.la[PAGE_LO-1:0]};
                            s_nxt.physical_addr_strobe = 1'b1;
                            s_nxt.seen = 1'b1;
                        end
                    end else begin
                        s_nxt.retry = 1'b1;
                        s_nxt.br    = 1'b1;
                        s_nxt.seen  = 1'b1;
                        s_nxt.tag[s_r.vict] = page;
                        s_nxt.st    = S_REQ;
                    end
                end
            end
            S_REQ: begin
                // wait for grant with the logical bus idle
                if (!bus.bg_n && !strobe) begin
                    s_nxt.st    = S_WALK;
                    s_nxt.pbusy = 1'b1;
                    s_nxt.wcnt  = 3'h0;
                    // descriptor address only, never data or code
                    s_nxt.pa    = {s_r.alc[0], s_r.tag[s_r.vict][15:0]};
                    s_nxt.physical_addr_strobe   = 1'b1;
                end
            end
            S_WALK: begin
                s_nxt.wcnt = s_r.wcnt + 3'h1;
                if (!bus.pack_n || s_r.wcnt == 3'(WALK_CYC)) begin
                    // only the descriptor word is kept, never other data
                    s_nxt.frm[s_r.vict] =
                        (PA_W-PAGE_LO)'(bus.pdata);
                    s_nxt.vld[s_r.vict] = 1'b1;
                    s_nxt.vict  = s_r.vict + 3'h1;
                    s_nxt.physical_addr_strobe   = 1'b0;
                    s_nxt.pbusy = 1'b0;
                    s_nxt.st    = S_DONE;
                end
            end
            S_DONE: begin
                s_nxt.br = 1'b0;
                s_nxt.st = S_IDLE;
            end
            default: s_nxt.st = S_IDLE;
        endcase
    end

    // single register stage for the whole end
    always_ff @(posedge clk) begin
        if (!nrst) begin
            s_r <= '0;
            s_r.coproc_interface_reg[CIR_RESP] <= RESP_IDLE;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign bus.dout_mmu = s_r.dout;
    assign bus.ack_n    = ~s_r.ack;
    assign bus.retry_n  = ~s_r.retry;
    assign bus.br_n     = ~s_r.br;
    assign bus.pa       = s_r.pa;
    assign bus.pas_n    = ~s_r.physical_addr_strobe;
    assign bus.pbusy    = s_r.pbusy;
    assign bus.fault    = s_r.fault;
    assign last_cmd     = s_r.coproc_interface_reg[CIR_CMD];
    assign walk_busy    = s_r.pbusy;
endmodule

//--- logic/mcsi_cpu.sv
// processor end: runs cpu space and memory cycles on the logical bus
// assumes the mmu answers with ack, retry or pas within a few cycles
`timescale 1ns/1ps
module mcsi_cpu
    import mcsi_pkg::*;
(
    input  wire logic            clk,
    input  wire logic            nrst,
    mcsi_if.cpu                  bus,
    input  wire logic            req,       // start a cycle, pulse
    input  wire logic            req_rw,    // high = read
    input  wire logic            req_cpu,   // cpu space cycle
    input  wire logic [LA_W-1:0] req_addr,  // address or cpu space word
    input  wire logic [D_W-1:0]  req_wdata, // write data
    input  wire logic            mem_done,  // memory finished, pulse
    output logic                 busy,      // cycle open
    output logic [D_W-1:0]       rdata,     // read data
    output logic                 done       // cycle ended, pulse
);
    import mcsi_pkg::*;

    typedef enum logic [1:0] {
        C_IDLE = 2'b00,   // no cycle
        C_RUN  = 2'b01,   // strobe out, waiting for answer
        C_GAP  = 2'b10,   // strobe dropped, retry pending
        C_HOLD = 2'b11    // bus granted away
    } mcsi_cst_e;

    typedef struct packed {
        mcsi_cst_e       st;
        logic [LA_W-1:0] la;
        logic [FC_W-1:0] fc;
        logic            rw;
        logic [D_W-1:0]  wd;
        logic [D_W-1:0]  rd;
        logic            as;
        logic            bg;
        logic            done;
    } mcsi_cpu_s;

    mcsi_cpu_s c_r, c_nxt;

    // next-state logic
    always_comb begin
        c_nxt      = c_r;
        c_nxt.done = 1'b0;
        unique case (c_r.st)
            C_IDLE: begin
                if (req) begin
                    c_nxt.la = req_addr;
                    // cpu space coded by function code only
                    c_nxt.fc = req_cpu ? FC_CPU : 3'h1;
                    c_nxt.rw = req_rw;
                    c_nxt.wd = req_wdata;
                    c_nxt.as = 1'b1;
                    c_nxt.st = C_RUN;
                end
            end
            C_RUN: begin
                if (!bus.retry_n) begin
                    c_nxt.as = 1'b0;
                    c_nxt.st = C_GAP;
                end else if (!bus.ack_n || mem_done || bus.fault) begin
                    c_nxt.rd   = bus.dout_mmu;
                    c_nxt.as   = 1'b0;
                    c_nxt.done = 1'b1;
                    c_nxt.st   = C_IDLE;
                end
            end
            C_GAP: begin
                // give the bus up while the mmu reloads
                if (!bus.br_n) begin
                    c_nxt.bg = 1'b1;
                    c_nxt.st = C_HOLD;
                end else begin
                    c_nxt.as = 1'b1;
                    c_nxt.st = C_RUN;
                end
            end
            C_HOLD: begin
                if (bus.br_n) begin
                    c_nxt.bg = 1'b0;
                    c_nxt.as = 1'b1;
                    c_nxt.st = C_RUN;
                end
            end
            default: c_nxt.st = C_IDLE;
        endcase
    end

    // register stage
    always_ff @(posedge clk) begin
        if (!nrst) begin
            c_r <= '0;
        end else begin
            c_r <= c_nxt;
        end
    end

    assign bus.la       = c_r.la;
    assign bus.fc       = c_r.fc;
    assign bus.as_n     = ~c_r.as;
    assign bus.rw       = c_r.rw;
    assign bus.dout_cpu = c_r.wd;
    assign bus.bg_n     = ~c_r.bg;
    assign busy         = (c_r.st != C_IDLE);
    assign rdata        = c_r.rd;
    assign done         = c_r.done;
endmodule

//--- tb/mcsi_props.sv
// concurrent checks on the bus between processor end and mmu end
// assumes one clock domain and the signals of mcsi_if as plain inputs
`timescale 1ns/1ps
module mcsi_props
    import mcsi_pkg::*;
(
    input wire logic            clk,
    input wire logic            nrst,
    input wire logic [LA_W-1:0] la,
    input wire logic [FC_W-1:0] fc,
    input wire logic            as_n,
    input wire logic            ack_n,
    input wire logic            retry_n,
    input wire logic            br_n,
    input wire logic            bg_n,
    input wire logic [PA_W-1:0] pa,
    input wire logic            pas_n,
    input wire logic            pbusy,
    input wire logic            fault
);
    // whole block runs on one clock, reset masks every check
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    // ack is a single-cycle pulse
    chk_ack_pulse: assert property (
        $fell(ack_n) |=> ack_n) else $error("ack held too long");
    // ack only inside a strobed cpu space cycle for our id
    chk_ack_space: assert property (
        !ack_n |-> !as_n && fc == FC_CPU && la[15:13] == MY_CPID)
        else $error("ack outside own cpu space");
    // interface register index must exist
    chk_cir_range: assert property (
        !ack_n && la[19:16] == TYPE_COP |-> la[4:0] < NUM_CIR)
        else $error("ack for missing interface register");
    // access level index must exist
    chk_alc_range: assert property (
        !ack_n && la[19:16] == TYPE_ALC |-> la[4:0] < NUM_ALC)
        else $error("ack for missing access level register");
    // a valid coprocessor access is answered promptly
    chk_cop_answer: assert property (
        $fell(as_n) && fc == FC_CPU && la[19:16] == TYPE_COP &&
        la[15:13] == MY_CPID && la[4:0] < NUM_CIR |-> ##[1:3] !ack_n)
        else $error("coprocessor access not answered");
    // translated strobe only for a strobed memory cycle
    chk_pas_source: assert property (
        $fell(pas_n) && !pbusy |-> !as_n && fc != FC_CPU)
        else $error("physical strobe without memory cycle");
    // a rejected access never reaches memory
    chk_fault_no_pas: assert property (
        fault |-> pas_n ##1 pas_n) else $error("strobe on faulted access");
    // miss asks for retry once and then for the bus
    chk_miss_busreq: assert property (
        $fell(retry_n) |=> retry_n ##[0:2] !br_n)
        else $error("retry not followed by bus request");
    // walk cycles only while the mmu owns the bus
    chk_walk_owner: assert property (
        !pas_n && pbusy |-> !br_n && !bg_n)
        else $error("walk without bus ownership");
    // descriptor read ends within its length
    chk_walk_bound: assert property (
        $fell(pas_n) && pbusy |-> ##[1:6] pas_n)
        else $error("walk cycle too long");
    // translated address keeps the page offset of the logical one
    chk_hit_offset: assert property (
        $fell(pas_n) && !pbusy |-> pa[PAGE_LO-1:0] == la[PAGE_LO-1:0])
        else $error("page offset not carried to physical address");

    // main scenarios reached
    cov_retry: cover property ($fell(retry_n));
    cov_bkpt:  cover property (!ack_n && la[19:16] == TYPE_BKPT);
    cov_fault: cover property (fault);
    cov_walk:  cover property ($fell(pas_n) && pbusy);
endmodule

//--- tb/testbench.sv
// self-checking bench: processor end and mmu end joined by mcsi_if
// the bench plays physical memory and feeds requests to the processor end
`timescale 1ns/1ps
module testbench;
    import mcsi_pkg::*;
    logic            clk = 1'b0;      // 20 mhz
    logic            nrst = 1'b0;     // sync reset, low
    logic            req = 1'b0, req_rw = 1'b0, req_cpu = 1'b0;
    logic [LA_W-1:0] req_addr = '0;   // request address
    logic [D_W-1:0]  req_wdata = '0;  // request data
    logic            mem_done = 1'b0; // memory finished pulse
    logic            mem_seen = 1'b0; // one done per strobe
    logic            wr_protect = 1'b0;
    logic            busy, done;      // processor end status
    logic [D_W-1:0]  rdata, last_cmd, rd;
    logic            walk_busy;
    logic [PA_W-1:0] walk_pa = '0, hit_pa = '0; // captured addresses
    int              err_total = 0, num_checks = 0, cyc_cnt = 0;
    int              retry_cnt = 0, ack_cnt = 0, fault_cnt = 0, pas_cnt = 0;
    logic [LA_W-1:0] bad [5];         // cycles that must be ignored

    mcsi_if bus ();
    mcsi_mmu u_mcsi_mmu (.clk(clk), .nrst(nrst), .bus(bus),
        .wr_protect(wr_protect), .last_cmd(last_cmd), .walk_busy(walk_busy));
    mcsi_cpu u_mcsi_cpu (.clk(clk), .nrst(nrst), .bus(bus), .req(req),
        .req_rw(req_rw), .req_cpu(req_cpu), .req_addr(req_addr),
        .req_wdata(req_wdata), .mem_done(mem_done), .busy(busy),
        .rdata(rdata), .done(done));
    mcsi_props u_mcsi_props (.clk(clk), .nrst(nrst), .la(bus.la),
        .fc(bus.fc), .as_n(bus.as_n), .ack_n(bus.ack_n),
        .retry_n(bus.retry_n), .br_n(bus.br_n), .bg_n(bus.bg_n),
        .pa(bus.pa), .pas_n(bus.pas_n), .pbusy(bus.pbusy),
        .fault(bus.fault));

    always #25 clk = ~clk;

    // memory model and event counters; pack_n answers one cycle late
    initial bus.pdata = 16'h0abc;
    always @(posedge clk) begin
        // held high through reset so the first walk sees an idle memory
        bus.pack_n <= !nrst || !(!bus.pas_n && bus.pbusy && bus.pack_n);
        mem_done   <= !bus.pas_n && !bus.pbusy && !mem_seen;
        mem_seen   <= !bus.pas_n && !bus.pbusy;
        if (!bus.pas_n && bus.pbusy) walk_pa <= bus.pa;
        if (!bus.pas_n && !bus.pbusy) hit_pa <= bus.pa;
        if ($fell(bus.pas_n) && !bus.pbusy) pas_cnt <= pas_cnt + 1;
        if (bus.retry_n === 1'b0) retry_cnt <= retry_cnt + 1;
        if (bus.ack_n === 1'b0) ack_cnt <= ack_cnt + 1;
        if (bus.fault === 1'b1) fault_cnt <= fault_cnt + 1;
    end

    // hang guard; the whole run needs well under 1000 cycles
    always @(posedge clk) begin
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == 3000) begin
            err_total++;
            $display("[ERR] %0t run did not finish", $time);
            conclude();
        end
    end

    task automatic conclude();
        $display("checks=%0d errors=%0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk16(input logic [15:0] got, exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t word %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t flag %b expected %b", $time, got, exp);
        end
    endtask

    task automatic do_rst(input int n);
        @(posedge clk);
        nrst <= 1'b0;
        req  <= 1'b0;
        repeat (n) @(posedge clk);
        nrst <= 1'b1;
    endtask

    // cpu space word: type, coprocessor id, word index
    function automatic logic [31:0] cs(input logic [3:0] t,
                                       input logic [2:0] id,
                                       input logic [4:0] idx);
        return {12'h000, t, id, 8'h00, idx};
    endfunction

    // one access; mode 1 must complete, 0 must not
    task automatic cyc(input logic rw, sp, input logic [31:0] a,
                       input logic [15:0] wd, input int mode);
        int n;
        n = 0;
        @(posedge clk);
        req <= 1'b1; req_rw <= rw; req_cpu <= sp;
        req_addr <= a; req_wdata <= wd;
        @(posedge clk);
        req <= 1'b0;
        #1;
        while (done !== 1'b1 && n < 60) begin
            @(posedge clk);
            #1;
            n++;
        end
        rd = rdata;
        // refused cycles leave the processor end waiting; clear it
        if (mode == 1) begin
            chk1(done, 1'b1);
            chk1(busy, 1'b0);
        end else begin
            chk1(done, 1'b0);
            chk1(busy, 1'b1);
            do_rst(2);
        end
    endtask

    initial begin
        int a0;
        bad = '{cs(TYPE_COP, 3'h1, CIR_CMD), cs(TYPE_COP, 3'h7, CIR_RESP),
                cs(TYPE_COP, 3'h0, 5'h0b), cs(TYPE_ALC, 3'h0, 5'h08),
                cs(4'h3, 3'h0, 5'h00)};
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        cyc(1'b0, 1'b1, cs(TYPE_COP, MY_CPID, CIR_CMD), 16'h8000, 1);
        chk16(last_cmd, 16'h8000);
        cyc(1'b1, 1'b1, cs(TYPE_COP, MY_CPID, CIR_RESP), 16'h0, 1);
        chk16(rd, RESP_FETCH);
        cyc(1'b0, 1'b1, cs(TYPE_COP, MY_CPID, CIR_OPER), 16'h1234, 1);
        cyc(1'b1, 1'b1, cs(TYPE_COP, MY_CPID, CIR_RESP), 16'h0, 1);
        chk16(rd, RESP_IDLE);
        cyc(1'b0, 1'b1, cs(TYPE_ALC, MY_CPID, 5'h00), 16'h00a5, 1);
        cyc(1'b1, 1'b1, cs(TYPE_ALC, MY_CPID, 5'h00), 16'h0, 1);
        chk16(rd, 16'h00a5);
        cyc(1'b0, 1'b1, cs(TYPE_BKPT, MY_CPID, 5'h04), 16'h1357, 1);
        cyc(1'b1, 1'b1, cs(TYPE_BKPT, MY_CPID, 5'h04), 16'h0, 1);
        chk16(rd, 16'h1357);
        // miss on a high address: retry, walk, then translated access
        a0 = retry_cnt;
        cyc(1'b1, 1'b0, 32'hfedc_b123, 16'h0, 1);
        chk1(retry_cnt != a0, 1'b1);
        chk16(walk_pa[31:16], 16'h00a5);
        chk16(walk_pa[15:0], 16'hedcb);
        chk16({4'h0, hit_pa[11:0]}, 16'h0123);
        chk16(hit_pa[27:12], 16'h0abc);
        chk1(walk_busy, 1'b0);
        // same page again must hit with no retry
        a0 = retry_cnt;
        cyc(1'b0, 1'b0, 32'hfedc_b9f0, 16'h5555, 1);
        chk1(retry_cnt == a0, 1'b1);
        chk16({4'h0, hit_pa[11:0]}, 16'h09f0);
        // protected write: fault and no translated strobe
        wr_protect <= 1'b1;
        a0 = pas_cnt;
        cyc(1'b0, 1'b0, 32'hfedc_b000, 16'h0001, 1);
        chk1(pas_cnt == a0, 1'b1);
        chk1(fault_cnt > 0, 1'b1);
        wr_protect <= 1'b0;
        // cycles for another id, missing index or unknown type
        foreach (bad[i]) begin
            a0 = ack_cnt;
            cyc(1'b1, 1'b1, bad[i], 16'h0, 0);
            chk1(ack_cnt == a0, 1'b1);
        end
        conclude();
    end
endmodule
